// *** src/cac_pkg.sv ***
// Purpose: constants for the charger control and status register bank
// Assumes: 8-bit registers reached over a byte-wide register port
// Notes:   field positions, offsets and reset values live here only
package cac_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CAC_CTRL_ADDR   = 8'h1b;
    localparam logic [7:0] CAC_STAT_ADDR   = 8'h1c;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int CAC_CTRL_GO      = 7;
    localparam int CAC_CTRL_ADC_EN  = 6;
    localparam int CAC_CTRL_ADC_CON = 5;
    localparam int CAC_CTRL_CH_BV   = 4;
    localparam int CAC_CTRL_CH_TH   = 3;
    localparam int CAC_CTRL_CH_A    = 2;
    localparam int CAC_CTRL_CH_B    = 1;
    localparam int CAC_CTRL_IRQ     = 0;

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int CAC_ST_VIN     = 7;
    localparam int CAC_ST_FAULT   = 6;
    localparam int CAC_ST_TEMP    = 5;
    localparam int CAC_ST_TAPER   = 4;
    localparam int CAC_ST_NOBAT   = 3;
    localparam int CAC_ST_PRE     = 2;
    localparam int CAC_ST_CONST_CURRENT_TIMEOUT    = 1;
    localparam int CAC_ST_TOTAL_TIME_TIMEOUT    = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CAC_CTRL_RST = 8'h00;
    localparam logic [7:0] CAC_STAT_RST = 8'h00;
    localparam logic [3:0] CAC_CH_RST   = 4'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CAC_CLK_MHZ        = 250;
    localparam int CAC_WAKE_TIME_S    = 8;
    localparam longint CAC_WAKE_CYCLES = longint'(CAC_WAKE_TIME_S) * 64'd1000000 * longint'(CAC_CLK_MHZ);
    localparam int CAC_CONV_CYCLES    = 16;

    // ----------------------------------------------------------------
    // adc sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CAC_ADC_IDLE = 2'b00,
        CAC_ADC_PICK = 2'b01,
        CAC_ADC_CONV = 2'b10
    } cac_adc_state_t;

endpackage : cac_pkg

// *** src/cac_adc_seq.sv ***
// Purpose: walks the enabled adc channels, one conversion at a time
// Assumes: the converter itself sits outside; this only sequences it
// Notes:   channel mask is latched at the start of each pass
`timescale 1ns/100ps
module cac_adc_seq
    import cac_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       adc_en,
    input  wire logic       continuous,
    input  wire logic [3:0] chan_en,
    input  wire logic       conv_done,
    // converter side
    output logic            conv_start_ff,
    output logic [1:0]      conv_chan_ff,
    output logic            busy_ff
);

    cac_adc_state_t state_ff;
    logic [3:0]     mask_ff;
    logic [1:0]     idx_ff;
    logic           once_done_ff;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] next_chan(input logic [3:0] m, input logic [1:0] from);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 0; i < 4; i++) begin
            if (m[i] && (2'(i) >= from) && (r == 3'h4)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    logic [2:0] pick;
    assign pick = next_chan(mask_ff, idx_ff);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff      <= CAC_ADC_IDLE;
            mask_ff       <= CAC_CH_RST;
            idx_ff        <= 2'h0;
            conv_start_ff <= 1'b0;
            conv_chan_ff  <= 2'h0;
            busy_ff       <= 1'b0;
            once_done_ff  <= 1'b0;
        end else begin
            conv_start_ff <= 1'b0;
            if (!adc_en) begin
                // clearing the enable stops at once, mid conversion too
                state_ff     <= CAC_ADC_IDLE;
                busy_ff      <= 1'b0;
                once_done_ff <= 1'b0;
            end else begin
                case (state_ff)
                    CAC_ADC_IDLE: begin
                        if (!once_done_ff || continuous) begin
                            // channels enabled later miss this pass
                            mask_ff  <= chan_en;
                            idx_ff   <= 2'h0;
                            busy_ff  <= 1'b1;
                            state_ff <= CAC_ADC_PICK;
                        end
                    end
                    CAC_ADC_PICK: begin
                        if (pick == 3'h4) begin
                            once_done_ff <= 1'b1;
                            busy_ff      <= 1'b0;
                            state_ff     <= CAC_ADC_IDLE;
                        end else begin
                            conv_chan_ff  <= pick[1:0];
                            conv_start_ff <= 1'b1;
                            state_ff      <= CAC_ADC_CONV;
                        end
                    end
                    CAC_ADC_CONV: begin
                        if (conv_done) begin
                            if (conv_chan_ff == 2'h3) begin
                                once_done_ff <= 1'b1;
                                busy_ff      <= 1'b0;
                                state_ff     <= CAC_ADC_IDLE;
                            end else begin
                                idx_ff   <= conv_chan_ff + 2'h1;
                                state_ff <= CAC_ADC_PICK;
                            end
                        end
                    end
                    default: begin
                        state_ff <= CAC_ADC_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // cac_adc_seq

// *** src/cac_top.sv ***
// Purpose: control and status registers of the charger with aux adc
// Assumes: serial interface decoded outside into a byte register port
// Notes:   charger analog loops and timers report as condition inputs
`timescale 1ns/100ps
module cac_top
    import cac_pkg::*;
#(
    parameter longint WAKE_CYCLES = CAC_WAKE_CYCLES
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata_ff,
    // charger condition inputs, one-cycle pulses except the voltage, temperature and no-battery levels
    input  wire logic       charger_input_voltage,
    input  wire logic       temp_bad,
    input  wire logic       bat_above_nobat,
    input  wire logic       bat_below_low,
    input  wire logic       bat_above_high,
    input  wire logic       precharge_timeout,
    input  wire logic       precharge_phase_done,
    input  wire logic       cc_timeout,
    input  wire logic       cc_phase_done,
    input  wire logic       taper_done,
    input  wire logic       total_timeout,
    // charger and adc outputs, plus the adc done input
    output logic            irq_ff,
    output logic            charge_on_ff,
    output logic            adc_conv_start_ff,
    output logic [1:0]      adc_conv_chan_ff,
    output logic            adc_busy_ff,
    input  wire logic       adc_conv_done
);

    typedef enum logic [2:0] {
        CAC_CHG_OFF  = 3'b000,
        CAC_CHG_WAKE = 3'b001,
        CAC_CHG_PRE  = 3'b010,
        CAC_CHG_CC   = 3'b011,
        CAC_CHG_CV   = 3'b100,
        CAC_CHG_HALT = 3'b101
    } cac_chg_state_t;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cac_chg_state_t chg_ff;
    logic           charge_go_ff;
    logic           adc_en_ff;
    logic           adc_cont_ff;
    logic [3:0]     chan_en_ff;
    logic           vin_ff;
    logic           vin_seen_ff;
    logic           battery_fault_ff;
    logic           temp_out_of_range_ff;
    logic           current_taper_done_ff;
    logic           no_battery_detected_ff;
    logic           const_current_timeout_ff;
    logic           total_time_timeout_ff;
    logic [35:0]    wake_cnt_ff;
    logic           irq_evt_ff;
    logic           irq_temp_ff;

    logic ctrl_wr;
    logic go_set;
    logic charging;
    logic fault_evt;
    logic done_evt;
    logic term_evt;
    logic wake_end;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    assign ctrl_wr  = reg_wr && addr_hit(reg_addr, CAC_CTRL_ADDR);
    assign go_set   = ctrl_wr && reg_wdata[CAC_CTRL_GO] && !charge_go_ff;
    assign charging = (chg_ff == CAC_CHG_PRE) || (chg_ff == CAC_CHG_CC) || (chg_ff == CAC_CHG_CV);
    assign wake_end = (chg_ff == CAC_CHG_WAKE) && (wake_cnt_ff == 36'(WAKE_CYCLES - 1));

    // battery faults count while a charge cycle runs, and a low battery also at the end of wake
    assign fault_evt = (charging && (bat_below_low || bat_above_high))
                     || ((chg_ff == CAC_CHG_PRE) && precharge_timeout)
                     || ((chg_ff == CAC_CHG_CC) && cc_timeout)
                     || (wake_end && bat_below_low);
    assign done_evt  = (chg_ff == CAC_CHG_CV) && !temp_bad && (taper_done || total_timeout);
    assign term_evt  = fault_evt || done_evt;

    // ----------------------------------------------------------------
    // charger sequence
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chg_ff      <= CAC_CHG_OFF;
            wake_cnt_ff <= 36'h0;
        end else if (!charge_go_ff) begin
            chg_ff      <= CAC_CHG_OFF;
            wake_cnt_ff <= 36'h0;
        end else begin
            case (chg_ff)
                CAC_CHG_OFF: begin
                    chg_ff      <= CAC_CHG_WAKE;
                    wake_cnt_ff <= 36'h0;
                end
                CAC_CHG_WAKE: begin
                    wake_cnt_ff <= wake_cnt_ff + 36'h1;
                    if (wake_end) begin
                        // no-battery halts but keeps the start bit up
                        chg_ff <= (bat_above_nobat || bat_below_low) ? CAC_CHG_HALT : CAC_CHG_PRE;
                    end
                end
                CAC_CHG_PRE: begin
                    if (!temp_bad && precharge_phase_done) begin
                        chg_ff <= CAC_CHG_CC;
                    end
                end
                CAC_CHG_CC: begin
                    if (!temp_bad && cc_phase_done) begin
                        chg_ff <= CAC_CHG_CV;
                    end
                end
                CAC_CHG_CV: begin
                    chg_ff <= chg_ff;
                end
                CAC_CHG_HALT: begin
                    chg_ff <= chg_ff;
                end
                default: begin
                    chg_ff <= CAC_CHG_OFF;
                end
            endcase
            if (term_evt) begin
                chg_ff <= CAC_CHG_HALT;
            end
        end
    end

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            charge_go_ff <= CAC_CTRL_RST[CAC_CTRL_GO];
            adc_en_ff    <= CAC_CTRL_RST[CAC_CTRL_ADC_EN];
            adc_cont_ff  <= CAC_CTRL_RST[CAC_CTRL_ADC_CON];
            chan_en_ff   <= CAC_CH_RST;
        end else begin
            if (ctrl_wr) begin
                charge_go_ff <= reg_wdata[CAC_CTRL_GO];
                adc_en_ff    <= reg_wdata[CAC_CTRL_ADC_EN];
                adc_cont_ff  <= reg_wdata[CAC_CTRL_ADC_CON];
                chan_en_ff   <= reg_wdata[CAC_CTRL_CH_BV:CAC_CTRL_CH_B];
            end
            // termination beats a same-cycle software write of one
            if (charge_go_ff && term_evt) begin
                charge_go_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            vin_ff                   <= CAC_STAT_RST[CAC_ST_VIN];
            vin_seen_ff              <= 1'b0;
            battery_fault_ff         <= CAC_STAT_RST[CAC_ST_FAULT];
            temp_out_of_range_ff     <= CAC_STAT_RST[CAC_ST_TEMP];
            current_taper_done_ff    <= CAC_STAT_RST[CAC_ST_TAPER];
            no_battery_detected_ff   <= CAC_STAT_RST[CAC_ST_NOBAT];
            const_current_timeout_ff <= CAC_STAT_RST[CAC_ST_CONST_CURRENT_TIMEOUT];
            total_time_timeout_ff    <= CAC_STAT_RST[CAC_ST_TOTAL_TIME_TIMEOUT];
        end else begin
            vin_ff      <= charger_input_voltage;
            vin_seen_ff <= 1'b1;
            // a new start wipes the outcome of the previous cycle
            if (go_set) begin
                battery_fault_ff         <= 1'b0;
                current_taper_done_ff    <= 1'b0;
                no_battery_detected_ff   <= 1'b0;
                const_current_timeout_ff <= 1'b0;
                total_time_timeout_ff    <= 1'b0;
            end
            if (charge_go_ff && fault_evt) begin
                battery_fault_ff <= 1'b1;
            end
            if (charge_go_ff && (chg_ff == CAC_CHG_CC) && cc_timeout) begin
                const_current_timeout_ff <= 1'b1;
            end
            if (charge_go_ff && done_evt && total_timeout && !taper_done) begin
                total_time_timeout_ff <= 1'b1;
            end
            if (charge_go_ff && done_evt && taper_done) begin
                current_taper_done_ff <= 1'b1;
            end
            if (charge_go_ff && wake_end && bat_above_nobat) begin
                no_battery_detected_ff <= 1'b1;
            end
            temp_out_of_range_ff <= charge_go_ff && charging && temp_bad;
        end
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    logic vin_edge;
    assign vin_edge = vin_seen_ff && (vin_ff != charger_input_voltage);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_evt_ff  <= 1'b0;
            irq_temp_ff <= 1'b0;
        end else begin
            // already high: further events merge into it
            if (ctrl_wr && !reg_wdata[CAC_CTRL_IRQ]) begin
                irq_evt_ff <= 1'b0;
            end
            if (vin_edge || (charge_go_ff && term_evt)) begin
                irq_evt_ff <= 1'b1;
            end
            // temperature source ignores software clears
            irq_temp_ff <= charge_go_ff && charging && temp_bad;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_ff       <= 1'b0;
            charge_on_ff <= 1'b0;
        end else begin
            irq_ff       <= irq_evt_ff || irq_temp_ff;
            // suspended while temperature is off, resumes by itself
            charge_on_ff <= charge_go_ff && charging && !temp_bad;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;
    assign ctrl_view = {charge_go_ff, adc_en_ff, adc_cont_ff, chan_en_ff, irq_ff};
    assign stat_view = {vin_ff, battery_fault_ff, temp_out_of_range_ff, current_taper_done_ff,
                        no_battery_detected_ff, (chg_ff == CAC_CHG_PRE),
                        const_current_timeout_ff, total_time_timeout_ff};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            // plain mux, reading changes nothing
            if (addr_hit(reg_addr, CAC_CTRL_ADDR)) begin
                reg_rdata_ff <= ctrl_view;
            end else if (addr_hit(reg_addr, CAC_STAT_ADDR)) begin
                reg_rdata_ff <= stat_view;
            end else begin
                reg_rdata_ff <= 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // adc sequencer
    // ----------------------------------------------------------------
    cac_adc_seq u_adc_seq (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .adc_en        (adc_en_ff),
        .continuous    (adc_cont_ff),
        .chan_en       (chan_en_ff),
        .conv_done     (adc_conv_done),
        .conv_start_ff (adc_conv_start_ff),
        .conv_chan_ff  (adc_conv_chan_ff),
        .busy_ff       (adc_busy_ff)
    );

endmodule // cac_top

// *** test/cac_top_asserts.sv ***
// Purpose: port-level checks of the charger register bank
// Assumes: one clock, synchronous active-low reset
// Notes:   control shadow follows software writes only
`timescale 1ns/100ps
module cac_top_asserts
    import cac_pkg::*;
#(
    parameter longint WAKE_CYCLES = CAC_WAKE_CYCLES
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_ff,
    // charger and adc
    input wire logic       charger_input_voltage,
    input wire logic       temp_bad,
    input wire logic       irq_ff,
    input wire logic       charge_on_ff,
    input wire logic       adc_conv_start_ff,
    input wire logic [1:0] adc_conv_chan_ff,
    input wire logic       adc_busy_ff
);
    // ----------------------------------------------------------------
    // helpers and properties
    // ----------------------------------------------------------------
    logic [7:0] sh_ff;
    wire        wr_c = reg_wr && reg_addr == CAC_CTRL_ADDR;
    wire        clr0 = wr_c && !reg_wdata[CAC_CTRL_IRQ];
    wire        rd_s = reg_rd && reg_addr == CAC_STAT_ADDR;
    wire        vin  = charger_input_voltage;
    always_ff @(posedge core_clk) begin
        if (!rst_n) sh_ff <= 8'h00;
        else if (wr_c) sh_ff <= reg_wdata;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_vin_irq; $past(rst_n) && $changed(vin) |-> ##[1:2] irq_ff; endproperty
    a_vin_irq: assert property (p_vin_irq) else $error("irq missed range change");
    property p_irq_fall; $fell(irq_ff) |-> $past(clr0, 2) || $past(temp_bad, 3); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without cause");
    property p_temp; $rose(temp_bad) && charge_on_ff |-> ##2 irq_ff && !charge_on_ff; endproperty
    a_temp: assert property (p_temp) else $error("no suspend on temperature");
    property p_rd_irq; reg_rd && reg_addr == CAC_CTRL_ADDR |=> reg_rdata_ff[0] == $past(irq_ff); endproperty
    a_rd_irq: assert property (p_rd_irq) else $error("control bit 0 differs from irq");
    property p_rd_vin; rd_s && $stable(vin) && $past(vin, 2) == vin |=> reg_rdata_ff[7] == $past(vin); endproperty
    a_rd_vin: assert property (p_rd_vin) else $error("status bit 7 wrong");
    property p_stop; wr_c && reg_wdata[7:6] == 2'b00 |-> ##3 !adc_busy_ff; endproperty
    a_stop: assert property (p_stop) else $error("adc still busy after disable");
    property p_chan; adc_conv_start_ff && sh_ff[6] |-> sh_ff[{1'b0, adc_conv_chan_ff} + 3'd1]; endproperty
    a_chan: assert property (p_chan) else $error("disabled channel converted");
    property p_single; $fell(adc_busy_ff) && sh_ff[6:5] == 2'b10 |-> !adc_busy_ff [*8]; endproperty
    a_single: assert property (p_single) else $error("single mode ran again");
    c_adc: cover property (adc_conv_start_ff && adc_conv_chan_ff == 2'd3);
    c_temp: cover property ($rose(temp_bad) && charge_on_ff);
    c_clr: cover property ($fell(irq_ff));
endmodule // cac_top_asserts

bind cac_top cac_top_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) cac_top_asserts_inst (.*);

// *** test/cac_host_model.sv ***
// Purpose: system controller model on the byte register port
// Assumes: one transfer at a time, one-cycle strobes
// Notes:   read data taken once the register has settled
`timescale 1ns/100ps
module cac_host_model
    import cac_pkg::*;
(
    // clock
    input  wire logic       core_clk,
    // register port
    output logic [7:0]      reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata_ff
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata_ff;
    endtask
    // zero in bit 0 drops the event irq, and the start bit with it
    task automatic clr();
        wr(CAC_CTRL_ADDR, 8'h00);
    endtask
    // channels first, else a pass may start without them
    task automatic adc_on(input logic [7:0] ch, input logic [7:0] md);
        wr(CAC_CTRL_ADDR, ch);
        wr(CAC_CTRL_ADDR, ch | md);
    endtask
endmodule // cac_host_model

// *** test/cac_top_tb_top.sv ***
// Purpose: self-checking bench of the charger register bank
// Assumes: wake period shortened through WAKE_CYCLES
// Notes:   converter answers three cycles after each start
`timescale 1ns/100ps
module cac_top_tb_top
    import cac_pkg::*;
();
    localparam int WK = 16;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_ff;
    logic        reg_wr, reg_rd, irq_ff, charge_on_ff, start_ff, busy_ff;
    logic        vin = 1'b0;
    logic        temp_bad = 1'b0;
    logic        nobat = 1'b0;
    logic [7:0]  ev = 8'h00;
    logic [2:0]  dly_ff = 3'h0;
    logic [1:0]  chan_ff;
    logic [1:0]  chq[$];
    int          bad_count = 0;
    int          num_checks = 0;
    int          j;
    logic [23:0] rows[6] = '{{CAC_CTRL_ADDR, 8'h1e, 8'h1e}, {CAC_CTRL_ADDR, 8'h01, 8'h00},
        {CAC_STAT_ADDR, 8'hff, 8'h00}, {8'h1d, 8'h5a, 8'h00}, {CAC_CTRL_ADDR, 8'h20, 8'h20}, 24'h1b0000};
    // phase, event index, expected status
    logic [15:0] term[6] = '{16'h00c0, 16'h05c0, 16'h11c2, 16'h14c0, 16'h2281, 16'h2390};

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        dly_ff <= {dly_ff[1:0], start_ff};
        if (start_ff) chq.push_back(chan_ff);
    end

    cac_top #(.WAKE_CYCLES(WK)) cac_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .charger_input_voltage(vin), .temp_bad(temp_bad), .bat_above_nobat(nobat), .bat_below_low(ev[5]),
        .bat_above_high(ev[4]), .precharge_timeout(ev[0]), .precharge_phase_done(ev[6]), .cc_timeout(ev[1]),
        .cc_phase_done(ev[7]), .taper_done(ev[3]), .total_timeout(ev[2]), .irq_ff(irq_ff),
        .charge_on_ff(charge_on_ff), .adc_conv_start_ff(start_ff), .adc_conv_chan_ff(chan_ff),
        .adc_busy_ff(busy_ff), .adc_conv_done(dly_ff[2]));
    cac_host_model cac_host_model_inst (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e); chk8({7'h0, g}, {7'h0, e}); endtask
    task automatic tick(input int n); repeat (n) @(posedge core_clk); endtask
    task automatic wc(input logic [7:0] d); cac_host_model_inst.wr(CAC_CTRL_ADDR, d); endtask
    task automatic cl(); cac_host_model_inst.clr(); endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        cac_host_model_inst.rd(a, d);
        chk8(d, e);
    endtask
    task automatic pulse(input int k);
        @(posedge core_clk);
        ev[k] <= 1'b1;
        tick(1);
        ev[k] <= 1'b0;
        tick(2);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        tick(5000);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        tick(10);
        rst_n <= 1'b1;
        tick(1);
        @(negedge core_clk) chk1(irq_ff, 1'b0);
        rc(CAC_STAT_ADDR, CAC_STAT_RST);
        $display("reset test done");
        foreach (rows[i]) begin
            cac_host_model_inst.wr(rows[i][23:16], rows[i][15:8]);
            rc(rows[i][23:16], rows[i][7:0]);
        end
        $display("register table done");
        tick(1);
        vin <= 1'b1;
        tick(3);
        rc(CAC_STAT_ADDR, 8'h80);
        rc(CAC_CTRL_ADDR, 8'h01);
        cl();
        rc(CAC_CTRL_ADDR, 8'h00);
        vin <= 1'b0;
        tick(3);
        @(negedge core_clk) chk1(irq_ff, 1'b1);
        cl();
        vin <= 1'b1;
        tick(3);
        cl();
        $display("input range test done");
        foreach (term[i]) begin
            wc(8'h80);
            tick(WK + 4);
            rc(CAC_STAT_ADDR, 8'h84);
            chk1(charge_on_ff, 1'b1);
            for (j = 0; j < int'(term[i][15:12]); j++) pulse(6 + j);
            pulse(int'(term[i][11:8]));
            rc(CAC_STAT_ADDR, term[i][7:0]);
            rc(CAC_CTRL_ADDR, 8'h01);
            chk1(charge_on_ff, 1'b0);
            cl();
        end
        $display("termination test done");
        wc(8'h80);
        tick(WK + 4);
        temp_bad <= 1'b1;
        tick(3);
        rc(CAC_STAT_ADDR, 8'ha4);
        chk1(charge_on_ff, 1'b0);
        wc(8'h80);
        rc(CAC_CTRL_ADDR, 8'h81);
        tick(1);
        temp_bad <= 1'b0;
        tick(3);
        rc(CAC_STAT_ADDR, 8'h84);
        rc(CAC_CTRL_ADDR, 8'h80);
        chk1(charge_on_ff, 1'b1);
        wc(8'h00);
        $display("temperature test done");
        nobat <= 1'b1;
        wc(8'h80);
        tick(WK + 4);
        rc(CAC_STAT_ADDR, 8'h88);
        rc(CAC_CTRL_ADDR, 8'h80);
        cl();
        rc(CAC_CTRL_ADDR, 8'h00);
        tick(1);
        nobat <= 1'b0;
        $display("no battery test done");
        chq.delete();
        cac_host_model_inst.adc_on(8'h12, 8'h40);
        tick(40);
        chk8(8'(chq.size()), 8'h02);
        chk8({4'h0, chq[0], chq[1]}, 8'h03);
        @(negedge core_clk) chk1(busy_ff, 1'b0);
        cac_host_model_inst.adc_on(8'h12, 8'h60);
        tick(40);
        chk1(chq.size() > 4, 1'b1);
        wc(8'h00);
        tick(3);
        @(negedge core_clk) chk1(busy_ff, 1'b0);
        $display("adc test done");
        summarize();
    end
endmodule // cac_top_tb_top
